// >>> logic/vfdsc_pkg.sv
// Constants shared by the display command interpreter.
// Assumes one 50 MHz core clock and pins sampled through synchronisers.
package vfdsc_pkg;

  // ==========================================================================
  // Command byte layout
  localparam int CMD_KIND_MSB = 7;
  localparam int CMD_KIND_LSB = 6;
  localparam logic [1:0] KIND_MODE = 2'h0;
  localparam logic [1:0] KIND_DATA = 2'h1;
  localparam logic [1:0] KIND_CTRL = 2'h2;
  localparam logic [1:0] KIND_ADDR = 2'h3;

  // ==========================================================================
  // Data setting field layout and operations
  localparam int DSET_OP_LSB = 0;
  localparam int DSET_FIXED_BIT = 2;
  localparam logic [1:0] OP_WR_DISP = 2'h0;
  localparam logic [1:0] OP_WR_LED = 2'h1;
  localparam logic [1:0] OP_RD_KEY = 2'h2;

  // ==========================================================================
  // Display control layout
  localparam int CTRL_ON_BIT = 3;

  // ==========================================================================
  // Reset values
  localparam logic [3:0] MODE_RST = 4'hF;
  localparam logic [3:0] DSET_RST = 4'h0;
  localparam logic [2:0] PULSE_RST = 3'h0;
  localparam logic [3:0] LED_RST = 4'h0;
  localparam logic [5:0] ADDR_RST = 6'h00;

  // ==========================================================================
  // Memory and key matrix sizes
  localparam int RAM_DEPTH = 36;
  localparam logic [5:0] ADDR_LAST = 6'h23;
  localparam logic [5:0] ADDR_TOP = 6'h3F;
  localparam int KEY_SOURCES = 16;
  localparam int KEY_BITS = 32;
  localparam logic [4:0] SEG_BASE = 5'h1C;
  localparam logic [3:0] GRID_MIN = 4'h4;
  localparam logic [3:0] GRID_MAX = 4'hC;
  localparam int KEY_SLOT_CYCLES = 500;

  // ==========================================================================
  // Write queue entry tags
  localparam logic [1:0] TAG_DISP = 2'h0;
  localparam logic [1:0] TAG_LED = 2'h1;
  localparam logic [1:0] TAG_ADDR = 2'h2;
  localparam int ENTRY_W = 11;
  localparam int FIFO_DEPTH = 8;

  // Serial frame states, Gray coded along idle, command, data
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_CMD = 2'b01,
    FR_DATA = 2'b11,
    FR_READ = 2'b10
  } vfdsc_frame_e;

endpackage : vfdsc_pkg

// >>> logic/vfdsc_top.sv
// Serial command interpreter, display RAM, key store and Led_output_port.
// Assumes raw pins from the host link and key matrix; scan logic reads RAM.
//
// Functional notes
// (RULE1) Sample data on serial clock rise, strobe low
// (RULE2) Shift read data on falling edge, LSB first
// (RULE3) First byte after strobe falls is command
// (RULE4) Strobe high mid-byte discards partial byte
// (RULE5) Mode command: b7,b6 zero; b5,b4 ignored
// (RULE6) Mode sets grid count and segment count
// (RULE7) Changed mode blanks display, stops key scan
// (RULE8) Same mode command does nothing at all
// (RULE9) Power-on mode: twelve digits, sixteen segments
// (RULE10) Display RAM 00H..23H, three bytes per digit
// (RULE11) Low nibble then high nibble per byte
// (RULE12) Data command: b7 zero, b6 one; b5,b4 ignored
// (RULE13) Data setting low bits reset to zero
// (RULE14) One stored bit per each of 32 keys
// (RULE15) Key returns latched at display cycle end
// (RULE16) Four sources per byte, first return first
// (RULE17) Key bytes read in order, LSB first
// (RULE18) LED byte bits b0..b3 drive lamps 1..4
// (RULE19) LED byte bits b4..b7 ignored
// (RULE20) Lamp outputs active low
// (RULE21) Lamp bits reset to zero, all lit
// (RULE22) Address above 23H drops data; reset 00H
// (RULE23) Host waits 1 us before first read clock
// (RULE24) Power-on: narrowest pulse, display off, no scan
// (RULE25) Address increments after each display byte
// (RULE26) Mode low bits decode grid and segment counts
// (RULE27) Data setting selects operation and addressing
// (RULE28) Open-drain output released unless reading

// ============================================================================
// Write queue between the serial receiver and the storage writer
module vfdsc_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Honest flags from the occupancy count
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];

  // Storage array, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap at depth, which need not be a power of two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : vfdsc_fifo

// ============================================================================
// Top level
module vfdsc_top #(
  parameter int SLOT_CYCLES = vfdsc_pkg::KEY_SLOT_CYCLES,
  parameter int QUEUE_DEPTH = vfdsc_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Host serial link pins
  input wire logic frame_strobe,
  input wire logic serial_clk,
  input wire logic serial_din,
  output logic serial_dout_o,
  output logic serial_dout_oe,
  // Key matrix return pins
  input wire logic key_return_first,
  input wire logic key_return_second,
  // Lamp pins, low means lit
  output logic lamp_out_first,
  output logic lamp_out_second,
  output logic lamp_out_third,
  output logic lamp_out_fourth,
  // Display scan side
  input wire logic disp_rd_en,
  input wire logic [5:0] disp_rd_addr,
  output logic [7:0] disp_rd_data,
  output logic display_on,
  output logic [2:0] pulse_width,
  output logic [3:0] grid_count,
  output logic [4:0] segment_count,
  output logic key_scan_active,
  output logic [3:0] key_source_sel,
  // Status
  output logic data_overrun
);

  // ==========================================================================
  // Pin synchronisers; only stage two and later are looked at
  logic sclk_s1, sclk_s2, sclk_s3;
  logic stb_s1, stb_s2, stb_s3;
  logic din_s1, din_s2;
  logic kr1_s1, kr1_s2;
  logic kr2_s1, kr2_s2;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h7;
      {stb_s1, stb_s2, stb_s3} <= 3'h7;
      {din_s1, din_s2} <= 2'h3;
      {kr1_s1, kr1_s2, kr2_s1, kr2_s2} <= 4'h0;
    end else begin
      {sclk_s1, sclk_s2, sclk_s3} <= {serial_clk, sclk_s1, sclk_s2};
      {stb_s1, stb_s2, stb_s3} <= {frame_strobe, stb_s1, stb_s2};
      {din_s1, din_s2} <= {serial_din, din_s1};
      {kr1_s1, kr1_s2} <= {key_return_first, kr1_s1};
      {kr2_s1, kr2_s2} <= {key_return_second, kr2_s1};
    end
  end

  // Edge detection; clock ignored while strobe is high
  wire sclk_rise = sclk_s2 && !sclk_s3 && !stb_s2; // RULE1
  wire sclk_fall = !sclk_s2 && sclk_s3 && !stb_s2; // RULE2

  // ==========================================================================
  // Serial receiver
  vfdsc_pkg::vfdsc_frame_e frame_r, frame_nxt;
  logic [7:0] shift_r;
  logic [2:0] bit_cnt_r;
  wire byte_done = sclk_rise && (bit_cnt_r == 3'h7);
  wire [7:0] rx_byte = {din_s2, shift_r[7:1]};
  wire is_cmd = byte_done && (frame_r == vfdsc_pkg::FR_CMD); // RULE3
  wire is_data = byte_done && (frame_r == vfdsc_pkg::FR_DATA);
  wire [1:0] cmd_kind = rx_byte[vfdsc_pkg::CMD_KIND_MSB:vfdsc_pkg::CMD_KIND_LSB];
  wire kind_mode = is_cmd && (cmd_kind == vfdsc_pkg::KIND_MODE); // RULE5
  wire kind_data = is_cmd && (cmd_kind == vfdsc_pkg::KIND_DATA); // RULE12
  wire kind_ctrl = is_cmd && (cmd_kind == vfdsc_pkg::KIND_CTRL);
  wire kind_addr = is_cmd && (cmd_kind == vfdsc_pkg::KIND_ADDR);
  wire rd_req = kind_data && (rx_byte[1:0] == vfdsc_pkg::OP_RD_KEY);

  // Frame state: strobe high always returns to idle
  always_comb begin
    frame_nxt = frame_r;
    case (frame_r)
      vfdsc_pkg::FR_IDLE: begin
        if (!stb_s2) frame_nxt = vfdsc_pkg::FR_CMD;
      end
      vfdsc_pkg::FR_CMD: begin
        if (rd_req) frame_nxt = vfdsc_pkg::FR_READ;
        else if (is_cmd) frame_nxt = vfdsc_pkg::FR_DATA;
      end
      default: begin
        frame_nxt = frame_r;
      end
    endcase
    if (stb_s2) frame_nxt = vfdsc_pkg::FR_IDLE; // RULE4
  end

  // Shift register collects LSB first; count cleared by strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame_r <= vfdsc_pkg::FR_IDLE;
      shift_r <= 8'h00;
      bit_cnt_r <= 3'h0;
    end else begin
      frame_r <= frame_nxt;
      if (stb_s2) begin
        bit_cnt_r <= 3'h0; // RULE4
      end else if (sclk_rise) begin
        shift_r <= rx_byte; // RULE1
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
    end
  end

  // ==========================================================================
  // Command registers
  logic [3:0] mode_r;
  logic [3:0] dset_r;
  logic [2:0] pulse_r;
  logic disp_on_r;
  wire mode_change = kind_mode && (rx_byte[3:0] != mode_r); // RULE8

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_r <= vfdsc_pkg::MODE_RST; // RULE9
      dset_r <= vfdsc_pkg::DSET_RST; // RULE13
      pulse_r <= vfdsc_pkg::PULSE_RST; // RULE24
      disp_on_r <= 1'b0; // RULE24
    end else begin
      if (mode_change) begin
        mode_r <= rx_byte[3:0]; // RULE26
        disp_on_r <= 1'b0; // RULE7
      end
      if (kind_data) dset_r <= rx_byte[3:0]; // RULE27
      if (kind_ctrl) begin
        disp_on_r <= rx_byte[vfdsc_pkg::CTRL_ON_BIT];
        pulse_r <= rx_byte[2:0];
      end
    end
  end

  // Mode decode: top code bit set means twelve grids; segments fill to 28
  wire [3:0] grids = mode_r[3] ? vfdsc_pkg::GRID_MAX
                               : vfdsc_pkg::GRID_MIN + {1'b0, mode_r[2:0]}; // RULE26
  assign grid_count = grids; // RULE6
  assign segment_count = vfdsc_pkg::SEG_BASE - {1'b0, grids}; // RULE6
  assign display_on = disp_on_r;
  assign pulse_width = pulse_r;

  // ==========================================================================
  // Write queue; address commands ride with data so order is kept
  wire [1:0] data_op = dset_r[1:0];
  wire [1:0] push_tag = kind_addr ? vfdsc_pkg::TAG_ADDR
                      : (data_op == vfdsc_pkg::OP_WR_LED) ? vfdsc_pkg::TAG_LED
                      : vfdsc_pkg::TAG_DISP;
  wire push_valid = kind_addr || is_data; // RULE27
  wire [vfdsc_pkg::ENTRY_W-1:0] push_entry = {dset_r[vfdsc_pkg::DSET_FIXED_BIT], push_tag,
                                              rx_byte};
  wire push_ready;
  wire pop_valid;
  wire [vfdsc_pkg::ENTRY_W-1:0] pop_entry;
  wire pop_ready = !disp_rd_en; // Scan reads win the RAM port

  vfdsc_fifo #(
    .WIDTH(vfdsc_pkg::ENTRY_W),
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .clk(core_clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_entry),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_entry)
  );

  // Link cannot be stalled, so a full queue loses the byte and flags it
  logic overrun_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      overrun_r <= 1'b0;
    end else if (push_valid && !push_ready) begin
      overrun_r <= 1'b1;
    end else if (frame_r == vfdsc_pkg::FR_IDLE && !stb_s2) begin
      overrun_r <= 1'b0;
    end
  end
  assign data_overrun = overrun_r;

  // ==========================================================================
  // Storage writer
  logic [7:0] ram [vfdsc_pkg::RAM_DEPTH];
  logic [5:0] addr_r;
  logic [3:0] led_r;
  logic [7:0] rd_data_r;
  wire pop = pop_valid && pop_ready;
  wire [1:0] pop_tag = pop_entry[9:8];
  wire pop_fixed = pop_entry[10];
  wire addr_ok = (addr_r <= vfdsc_pkg::ADDR_LAST); // RULE22
  wire ram_we = pop && (pop_tag == vfdsc_pkg::TAG_DISP) && addr_ok;

  // RAM writes and scan reads; each byte holds low then high nibble
  always_ff @(posedge core_clk) begin
    if (ram_we) ram[addr_r] <= pop_entry[7:0]; // RULE10 RULE11
  end

  // Address pointer and lamp port
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_r <= vfdsc_pkg::ADDR_RST; // RULE22
      led_r <= vfdsc_pkg::LED_RST; // RULE21
      rd_data_r <= 8'h00;
    end else begin
      if (pop && pop_tag == vfdsc_pkg::TAG_ADDR) begin
        addr_r <= pop_entry[5:0];
      end else if (pop && pop_tag == vfdsc_pkg::TAG_DISP && !pop_fixed
                   && addr_r != vfdsc_pkg::ADDR_TOP) begin
        addr_r <= addr_r + 6'h01; // RULE25
      end
      if (pop && pop_tag == vfdsc_pkg::TAG_LED) begin
        led_r <= pop_entry[3:0]; // RULE18 RULE19
      end
      if (disp_rd_en) begin
        rd_data_r <= (disp_rd_addr <= vfdsc_pkg::ADDR_LAST) ? ram[disp_rd_addr] : 8'h00;
      end
    end
  end
  assign disp_rd_data = rd_data_r;

  // Stored one drives pin high, lamp dark
  assign lamp_out_first = led_r[0]; // RULE20
  assign lamp_out_second = led_r[1];
  assign lamp_out_third = led_r[2];
  assign lamp_out_fourth = led_r[3];

  // ==========================================================================
  // Key scan: one slot per source, running only while display is on
  logic [15:0] slot_cnt_r;
  logic [3:0] src_r;
  logic [vfdsc_pkg::KEY_BITS-1:0] key_work_r;
  logic [vfdsc_pkg::KEY_BITS-1:0] key_store_r;
  logic [vfdsc_pkg::KEY_BITS-1:0] key_merge;
  wire slot_end = disp_on_r && (slot_cnt_r == 16'(SLOT_CYCLES - 1)); // RULE7

  // Bit 2s is first return, 2s+1 second return of source s
  for (genvar g = 0; g < vfdsc_pkg::KEY_SOURCES; g++) begin : g_key
    assign key_merge[2*g +: 2] = (src_r == 4'(g)) ? {kr2_s2, kr1_s2}
                                                  : key_work_r[2*g +: 2]; // RULE16
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slot_cnt_r <= 16'h0000;
      src_r <= 4'h0;
      key_work_r <= 32'h0000_0000;
      key_store_r <= 32'h0000_0000;
    end else if (!disp_on_r) begin
      slot_cnt_r <= 16'h0000; // RULE7
      src_r <= 4'h0;
    end else if (slot_end) begin
      slot_cnt_r <= 16'h0000;
      src_r <= src_r + 4'h1;
      key_work_r <= key_merge; // RULE14
      if (src_r == 4'hF) key_store_r <= key_merge; // RULE15
    end else begin
      slot_cnt_r <= slot_cnt_r + 16'h0001;
    end
  end
  assign key_scan_active = disp_on_r;
  assign key_source_sel = src_r;

  // ==========================================================================
  // Read-back: snapshot at the command so a scan cannot tear the bytes
  logic [vfdsc_pkg::KEY_BITS-1:0] rd_snap_r;
  logic [4:0] rd_idx_r;
  logic dout_low_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_snap_r <= 32'h0000_0000;
      rd_idx_r <= 5'h00;
      dout_low_r <= 1'b0;
    end else if (rd_req) begin
      rd_snap_r <= key_store_r;
      rd_idx_r <= 5'h00;
      dout_low_r <= 1'b0;
    end else if (frame_r != vfdsc_pkg::FR_READ || stb_s2) begin
      dout_low_r <= 1'b0; // RULE28
    end else if (sclk_fall) begin
      dout_low_r <= !rd_snap_r[rd_idx_r]; // RULE2 RULE17
      rd_idx_r <= rd_idx_r + 5'h01; // RULE17
    end
  end

  // Open drain: only ever pulls low
  assign serial_dout_o = 1'b0;
  assign serial_dout_oe = dout_low_r; // RULE28

endmodule : vfdsc_top

// >>> sim/vfdsc_top_assertions.sv
// Checker for the display command interpreter, watching top ports only.
// Assumes a pulled-up data wire and a raw serial clock from the host.
module vfdsc_top_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Host link
  input wire logic frame_strobe,
  input wire logic serial_clk,
  input wire logic serial_dout_o,
  input wire logic serial_dout_oe,
  // Scan side
  input wire logic disp_rd_en,
  input wire logic [5:0] disp_rd_addr,
  input wire logic [7:0] disp_rd_data,
  input wire logic display_on,
  input wire logic [3:0] grid_count,
  input wire logic [4:0] segment_count,
  input wire logic key_scan_active,
  input wire logic [3:0] key_source_sel
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ==========================================================================
  // Helper: cycles since the last serial clock fall, saturating
  logic clk_q_r;
  logic [3:0] since_fall_r;
  logic [3:0] since_fall_nxt;
  assign since_fall_nxt = (clk_q_r && !serial_clk) ? 4'h0 :
                          (since_fall_r == 4'hF) ? 4'hF : since_fall_r + 4'h1;
  // Short process; saturation keeps a long idle from wrapping to a false fall
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_q_r <= 1'b1;
      since_fall_r <= 4'hF;
    end else begin
      clk_q_r <= serial_clk;
      since_fall_r <= since_fall_nxt;
    end
  end

  // ==========================================================================
  // Properties
  sequence strobe_idle_s;
    frame_strobe [*5];
  endsequence
  sequence display_dark_s;
    !display_on [*3];
  endsequence

  dout_zero_a: assert property (serial_dout_o == 1'b0)
    else $error("data output value not low");
  oe_release_a: assert property (strobe_idle_s |-> !serial_dout_oe)
    else $error("data output held outside frame");
  oe_timing_a: assert property ($rose(serial_dout_oe) |-> since_fall_r <= 4'h5)
    else $error("data output changed away from clock fall");
  scan_follow_a: assert property (key_scan_active == display_on)
    else $error("key scan not following display state");
  seg_grid_a: assert property (segment_count == 5'h1C - {1'b0, grid_count})
    else $error("segment count not matching grid count");
  grid_range_a: assert property (grid_count >= 4'h4 && grid_count <= 4'hC)
    else $error("grid count out of range");
  mode_blank_a: assert property ($changed(grid_count) |-> ##[0:3] !display_on)
    else $error("mode change left display on");
  scan_idle_a: assert property (display_dark_s |-> key_source_sel == 4'h0)
    else $error("key scan moving while display off");
  rd_range_a: assert property (disp_rd_en && disp_rd_addr > 6'h23 |=>
    disp_rd_data == 8'h00)
    else $error("data returned above last address");
  oe_frame_a: assert property ($rose(serial_dout_oe) |-> !frame_strobe)
    else $error("data output pulled low outside a frame");
endmodule : vfdsc_top_assertions

bind vfdsc_top vfdsc_top_assertions chk_u (.core_clk, .rst, .frame_strobe, .serial_clk,
  .serial_dout_o, .serial_dout_oe, .disp_rd_en, .disp_rd_addr, .disp_rd_data, .display_on,
  .grid_count, .segment_count, .key_scan_active, .key_source_sel);

// >>> sim/vfdsc_host_model.sv
// Host controller model for the strobed three-wire link.
// Assumes tasks are entered right after a core clock edge.
module vfdsc_host_model (
  // Clock
  input wire logic core_clk,
  // Link pins
  output logic frame_strobe,
  output logic serial_clk,
  output logic serial_din,
  input wire logic dout_wire
);
  timeunit 1ns;
  timeprecision 1ps;

  // Link idles with strobe high and clock parked high
  initial begin
    frame_strobe = 1'b1;
    serial_clk = 1'b1;
    serial_din = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_cyc

  // Frame start; first byte after this is the command
  task automatic open_frame();
    frame_strobe <= 1'b0;
    wait_cyc(4);
  endtask : open_frame

  // Released data line flips so no stale bit is mistaken for data
  task automatic close_frame();
    wait_cyc(4);
    frame_strobe <= 1'b1;
    serial_din <= ~serial_din;
    wait_cyc(8);
  endtask : close_frame

  // Bits LSB first, set up on the fall, taken on the rise (160 ns period)
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      serial_clk <= 1'b0;
      serial_din <= b[i];
      wait_cyc(4);
      serial_clk <= 1'b1;
      wait_cyc(4);
    end
  endtask : send_bits

  // Each bit read late in the low phase, after the device has shifted
  task automatic recv_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      serial_clk <= 1'b0;
      wait_cyc(4);
      b[i] = dout_wire;
      serial_clk <= 1'b1;
      wait_cyc(4);
    end
  endtask : recv_byte
endmodule : vfdsc_host_model

// >>> sim/vfdsc_top_tb.sv
// Self-checking bench for the display command interpreter.
// Assumes the host model drives the link; key slots shortened to 4 cycles.
module vfdsc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  logic core_clk = 1'b0;
  logic rst;
  logic frame_strobe, serial_clk, serial_din, serial_dout_o, serial_dout_oe, dout_wire;
  logic key_return_first, key_return_second, disp_rd_en, data_overrun;
  logic lamp_out_first, lamp_out_second, lamp_out_third, lamp_out_fourth;
  logic [5:0] disp_rd_addr;
  logic [7:0] disp_rd_data, g, b;
  logic display_on, key_scan_active;
  logic [2:0] pulse_width;
  logic [3:0] grid_count, key_source_sel, lamps;
  logic [4:0] segment_count;
  int error_cnt = 0;
  int compares = 0;

  // Pull-up on the open-drain wire; lamps gathered for compares
  assign dout_wire = serial_dout_oe ? serial_dout_o : 1'b1;
  assign lamps = {lamp_out_fourth, lamp_out_third, lamp_out_second, lamp_out_first};

  always #10 core_clk = ~core_clk;

  // Second return pressed on source index 5 only, so byte order shows in the read
  always @(posedge core_clk) key_return_second <= (key_source_sel == 4'h5);

  vfdsc_top #(.SLOT_CYCLES(4), .QUEUE_DEPTH(8)) dut_u (.core_clk, .rst, .frame_strobe,
    .serial_clk, .serial_din, .serial_dout_o, .serial_dout_oe, .key_return_first,
    .key_return_second, .lamp_out_first, .lamp_out_second, .lamp_out_third, .lamp_out_fourth,
    .disp_rd_en, .disp_rd_addr, .disp_rd_data, .display_on, .pulse_width, .grid_count,
    .segment_count, .key_scan_active, .key_source_sel, .data_overrun);

  vfdsc_host_model host_u (.core_clk, .frame_strobe, .serial_clk, .serial_din, .dout_wire);

  // ==========================================================================
  // Tasks
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One frame of n bytes, lowest byte of w first
  task automatic frame(input logic [31:0] w, input int n);
    host_u.open_frame();
    for (int i = 0; i < n; i++) host_u.send_bits(w[8*i +: 8], 8);
    host_u.close_frame();
  endtask : frame

  task automatic ram_chk(input logic [5:0] a, input logic [7:0] e);
    disp_rd_en <= 1'b1;
    disp_rd_addr <= a;
    @(posedge core_clk);
    disp_rd_en <= 1'b0;
    @(posedge core_clk);
    chk("ram", disp_rd_data, e);
  endtask : ram_chk

  task automatic stop_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  // Hang guard: running out counts as a mismatch
  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    stop_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    key_return_first = 1'b1;
    disp_rd_en = 1'b0;
    disp_rd_addr = 6'h00;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("lamps", {4'h0, lamps}, 8'h00);
    chk("grid", {4'h0, grid_count}, 8'h0C);
    chk("seg", {3'h0, segment_count}, 8'h10);
    chk("ctrl", {3'h0, display_on, 1'b0, pulse_width}, 8'h00);
    chk("oe", {7'h0, serial_dout_oe}, 8'h00);
    // Lamp writes, a cut byte, then a command with ignored bits set
    frame(32'hA541, 2);
    chk("lamps", {4'h0, lamps}, 8'h05);
    host_u.open_frame();
    host_u.send_bits(8'h41, 8);
    host_u.send_bits(8'hFA, 4);
    host_u.close_frame();
    chk("lamps", {4'h0, lamps}, 8'h05);
    frame(32'h5A71, 2);
    chk("lamps", {4'h0, lamps}, 8'h0A);
    // Incrementing writes running past the last address
    frame(32'h40, 1);
    frame(32'h332211E2, 4);
    ram_chk(6'h22, 8'h11);
    ram_chk(6'h23, 8'h22);
    ram_chk(6'h24, 8'h00);
    // Fixed address: second byte overwrites the first
    frame(32'h74, 1);
    frame(32'h8877C5, 3);
    ram_chk(6'h05, 8'h88);
    // Display on, then the same mode again with ignored bits set
    frame(32'h8F, 1);
    chk("ctrl", {3'h0, display_on, 1'b0, pulse_width}, 8'h17);
    frame(32'h3F, 1);
    chk("ctrl", {3'h0, display_on, 1'b0, pulse_width}, 8'h17);
    // Mode codes 0 to 8; each change blanks the display
    for (int m = 0; m <= 8; m++) begin
      frame(32'(m), 1);
      g = (m == 8) ? 8'h0C : 8'h04 + 8'(m);
      chk("grid", {4'h0, grid_count}, g);
      chk("seg", {3'h0, segment_count}, 8'h1C - g);
      chk("on", {7'h0, display_on}, 8'h00);
    end
    // Key read after a full scan with the first return active and the second on source 5
    frame(32'h88, 1);
    repeat (200) @(posedge core_clk);
    host_u.open_frame();
    host_u.send_bits(8'h42, 8);
    host_u.wait_cyc(60);
    for (int k = 0; k < 4; k++) begin
      host_u.recv_byte(b);
      chk("key", b, (k == 1) ? 8'h5D : 8'h55);
    end
    host_u.close_frame();
    // Stalled drain: queue fills and refuses, then drains
    frame(32'h40, 1);
    disp_rd_en <= 1'b1;
    host_u.open_frame();
    host_u.send_bits(8'hC0, 8);
    for (int i = 0; i < 12; i++) host_u.send_bits(8'hD0 + 8'(i), 8);
    host_u.close_frame();
    chk("overrun", {7'h0, data_overrun}, 8'h01);
    disp_rd_en <= 1'b0;
    host_u.wait_cyc(20);
    ram_chk(6'h00, 8'hD0);
    frame(32'h40, 1);
    chk("overrun", {7'h0, data_overrun}, 8'h00);
    stop_test();
  end
endmodule : vfdsc_top_tb
